// File: core/hmdp_defines.vh
// constants for the host memory port
`ifndef HMDP_DEFINES_VH
`define HMDP_DEFINES_VH
`define HMDP_ADDR_OVL_OFFSET   14'h3fe0
`define HMDP_CONFIG_OFFSET     14'h3fe7
`define HMDP_CTRL_REGION_BASE  14'h3fe0
`define HMDP_SHORT_READ_BIT    14
`define HMDP_OVL_FLAG_BIT      15
`define HMDP_MEM_SEL_BIT       14
`define HMDP_ADDR_MSB          13
`define HMDP_OVL_MSB           7
`define HMDP_BOOT_MODE_HOST    3'h5
`define HMDP_ADDR_RESET        14'h0000
`define HMDP_OVL_RESET         8'h00
`define HMDP_FIFO_WIDTH        39
`define HMDP_FIFO_DEPTH        16
`define HMDP_FIFO_AW           4
`endif

// File: core/hmdp_fifo.v
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module hmdp_fifo #(
    parameter WIDTH = 39,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    output wire             empty_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign empty_o     = ~out_valid_o;
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// File: core/hmdp_port.v
// host memory port: address latch, host reads/writes of on-chip memory, host boot
`timescale 1ns/1ps
//
// Overview of operation
// - host reads and writes program and data memory, one transfer per data word, two per program word.
// - host writes into the control register region are dropped.
// - latched word with bit 15 set loads the overlay from bits 7:0.
// - bit 15 clear loads address from bits 13:0, memory choice bit 14.
// - one 16-bit shared bus; program words move as two halves.
// - host strobes are resynchronised; core keeps running during transfers.
// - latched address increments after each data word and after the second half of each program word.
// - latch on falling address strobe, or select rising during the strobe.
// - select plus read/write starts access: one sync cycle, one memory cycle.
// - latched address is never returned to the host.
// - address/overlay register also reachable by the core at its data address.
// - configuration bit 14 picks the short-read timing behaviour.
// - boot mode pins C=1, B=0, A=1 at reset select host boot.
// - host boot holds execution until program location zero is written.
`include "hmdp_defines.vh"
module hmdp_port (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        host_port_select_n_i,
    input  wire        address_latch_strobe_i,
    input  wire        host_read_strobe_n_i,
    input  wire        host_write_strobe_n_i,
    input  wire [15:0] host_addr_data_bus_i,
    output reg  [15:0] host_addr_data_bus_o,
    output wire [15:0] host_addr_data_bus_oe_o,
    output wire        host_ack_n_o,
    input  wire [2:0]  boot_mode_i,
    output reg         boot_hold_o,
    input  wire        core_reg_wr_i,
    input  wire [13:0] core_reg_addr_i,
    input  wire [15:0] core_reg_wdata_i,
    output reg  [15:0] core_reg_rdata_o,
    output wire        mem_req_o,
    output wire        mem_we_o,
    output wire        mem_program_o,
    output wire [13:0] mem_addr_o,
    output wire [23:0] mem_wdata_o,
    output wire [7:0]  overlay_select_o,
    input  wire        mem_ready_i,
    input  wire [23:0] mem_rdata_i
);
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_SYNC  = 5'h02;
    localparam [4:0] ST_WACC  = 5'h04;
    localparam [4:0] ST_RACC  = 5'h08;
    localparam [4:0] ST_RDATA = 5'h10;

    // two-stage synchronisers; stage one feeds only stage two
    reg  [3:0]  strobe_s1;
    reg  [3:0]  strobe_s2;
    reg  [15:0] bus_s1;
    reg  [15:0] bus_s2;
    reg  [3:0]  strobe_prev;
    wire        sel_act;
    wire        ial_act;
    wire        rd_act;
    wire        wr_act;

    reg  [4:0]  state;
    reg  [4:0]  next_state;
    reg  [13:0] host_address_latch_reg;
    reg         mem_program;
    reg  [7:0]  overlay_select;
    reg         short_read_mode;
    reg         served;
    reg         is_write;
    reg         pm_half;
    reg  [15:0] pm_upper;
    reg  [7:0]  pm_low;
    reg  [15:0] wdata;
    reg         boot_host;
    reg         boot_caught;
    reg         read_valid;

    wire        latch_evt;
    wire        access_req;
    wire        fifo_in_valid;
    wire        fifo_in_ready;
    wire [38:0] fifo_in_data;
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [38:0] fifo_out_data;
    wire        fifo_empty;
    wire        ctrl_hit;
    wire        read_issue;
    wire        core_addr_wr;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            strobe_s1   <= 4'hf;
            strobe_s2   <= 4'hf;
            strobe_prev <= 4'hf;
            bus_s1      <= 16'h0000;
            bus_s2      <= 16'h0000;
        end else begin
            strobe_s1   <= {host_port_select_n_i, ~address_latch_strobe_i,
                            host_read_strobe_n_i, host_write_strobe_n_i};
            strobe_s2   <= strobe_s1;
            strobe_prev <= strobe_s2;
            bus_s1      <= host_addr_data_bus_i;
            bus_s2      <= bus_s1;
        end
    end

    assign sel_act = ~strobe_s2[3];
    assign ial_act = ~strobe_s2[2];
    assign rd_act  = ~strobe_s2[1];
    assign wr_act  = ~strobe_s2[0];

    // falling latch strobe, or select released while latch strobe high
    assign latch_evt = (~strobe_prev[2] & strobe_s2[2])
                     | (~strobe_prev[3] & strobe_s2[3] & ial_act);
    assign access_req = sel_act & ~ial_act & (rd_act | wr_act) & ~served;
    assign core_addr_wr = core_reg_wr_i & (core_reg_addr_i == `HMDP_ADDR_OVL_OFFSET);

    // dm control region cannot be written from the host
    assign ctrl_hit = ~mem_program & (host_address_latch_reg >= `HMDP_CTRL_REGION_BASE);

    // write path: full program word or data word goes through the fifo
    assign fifo_in_valid = (state == ST_WACC) & (~mem_program | pm_half) & ~ctrl_hit;
    assign fifo_in_data  = {mem_program, host_address_latch_reg,
                            mem_program ? {pm_upper, wdata[7:0]} : {8'h00, wdata}};
    assign fifo_out_ready = mem_ready_i;
    assign read_issue     = (state == ST_RACC) & fifo_empty & mem_ready_i & ~(mem_program & pm_half);

    hmdp_fifo #(
        .WIDTH (`HMDP_FIFO_WIDTH),
        .DEPTH (`HMDP_FIFO_DEPTH),
        .AW    (`HMDP_FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data),
        .empty_o     (fifo_empty)
    );

    // one shared memory port: queued writes first, then reads
    assign mem_req_o        = fifo_out_valid | read_issue;
    assign mem_we_o         = fifo_out_valid;
    assign mem_program_o    = fifo_out_valid ? fifo_out_data[38] : mem_program;
    assign mem_addr_o       = fifo_out_valid ? fifo_out_data[37:24] : host_address_latch_reg;
    assign mem_wdata_o      = fifo_out_data[23:0];
    assign overlay_select_o = overlay_select;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (access_req) begin
                    next_state = ST_SYNC;
                end
            end
            ST_SYNC: begin
                next_state = is_write ? ST_WACC : ST_RACC;
            end
            ST_WACC: begin
                if (fifo_in_ready || !fifo_in_valid) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RACC: begin
                if (mem_program && pm_half) begin
                    next_state = ST_IDLE;
                end else if (read_issue) begin
                    next_state = ST_RDATA;
                end
            end
            ST_RDATA: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ready only when idle and no access still waiting
    assign host_ack_n_o = ~((state == ST_IDLE) & ~access_req);

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state                  <= ST_IDLE;
            host_address_latch_reg <= `HMDP_ADDR_RESET;
            mem_program            <= 1'b0;
            overlay_select         <= `HMDP_OVL_RESET;
            served                 <= 1'b0;
            is_write               <= 1'b0;
            pm_half                <= 1'b0;
            pm_upper               <= 16'h0000;
            pm_low                 <= 8'h00;
            wdata                  <= 16'h0000;
            host_addr_data_bus_o   <= 16'h0000;
            read_valid             <= 1'b0;
        end else begin
            state <= next_state;
            if (!(sel_act && (rd_act || wr_act))) begin
                served <= 1'b0;
            end else if (state == ST_IDLE && access_req) begin
                served   <= 1'b1;
                is_write <= wr_act;
                wdata    <= bus_s2;
            end
            if (!sel_act || !rd_act) begin
                read_valid <= 1'b0;
            end
            if (latch_evt && state == ST_IDLE) begin
                if (bus_s2[`HMDP_OVL_FLAG_BIT]) begin
                    overlay_select <= bus_s2[`HMDP_OVL_MSB:0];
                end else begin
                    host_address_latch_reg <= bus_s2[`HMDP_ADDR_MSB:0];
                    mem_program            <= bus_s2[`HMDP_MEM_SEL_BIT];
                    pm_half                <= 1'b0;
                end
            end else if (core_addr_wr) begin
                if (core_reg_wdata_i[`HMDP_OVL_FLAG_BIT]) begin
                    overlay_select <= core_reg_wdata_i[`HMDP_OVL_MSB:0];
                end else begin
                    host_address_latch_reg <= core_reg_wdata_i[`HMDP_ADDR_MSB:0];
                    mem_program            <= core_reg_wdata_i[`HMDP_MEM_SEL_BIT];
                    pm_half                <= 1'b0;
                end
            end else begin
                case (state)
                    ST_WACC: begin
                        if (mem_program && !pm_half) begin
                            pm_upper <= wdata;
                            pm_half  <= 1'b1;
                        end else if (fifo_in_ready || !fifo_in_valid) begin
                            pm_half                <= 1'b0;
                            host_address_latch_reg <= host_address_latch_reg + 14'h0001;
                        end
                    end
                    ST_RACC: begin
                        if (mem_program && pm_half) begin
                            host_addr_data_bus_o   <= {8'h00, pm_low};
                            read_valid             <= 1'b1;
                            pm_half                <= 1'b0;
                            host_address_latch_reg <= host_address_latch_reg + 14'h0001;
                        end
                    end
                    ST_RDATA: begin
                        read_valid <= 1'b1;
                        if (mem_program) begin
                            host_addr_data_bus_o <= mem_rdata_i[23:8];
                            pm_low               <= mem_rdata_i[7:0];
                            pm_half              <= 1'b1;
                        end else begin
                            host_addr_data_bus_o   <= mem_rdata_i[15:0];
                            host_address_latch_reg <= host_address_latch_reg + 14'h0001;
                        end
                    end
                    default: begin
                        pm_half <= pm_half;
                    end
                endcase
            end
        end
    end

    // mode 0: drive only during the read strobe; mode 1: one cycle past the read strobe
    assign host_addr_data_bus_oe_o = {16{sel_act & (rd_act | (short_read_mode & read_valid))
                                        & (read_valid | rd_act & served & ~is_write & state == ST_IDLE)}};

    // configuration register and boot hold
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            short_read_mode <= 1'b0;
            boot_caught     <= 1'b0;
            boot_host       <= 1'b0;
            boot_hold_o     <= 1'b1;
        end else begin
            if (core_reg_wr_i && core_reg_addr_i == `HMDP_CONFIG_OFFSET) begin
                short_read_mode <= core_reg_wdata_i[`HMDP_SHORT_READ_BIT];
            end
            if (!boot_caught) begin
                boot_caught <= 1'b1;
                boot_host   <= (boot_mode_i == `HMDP_BOOT_MODE_HOST);
                boot_hold_o <= (boot_mode_i == `HMDP_BOOT_MODE_HOST);
            end else if (boot_host && mem_req_o && mem_we_o && mem_ready_i && fifo_out_data[38]
                         && fifo_out_data[37:24] == 14'h0000) begin
                boot_hold_o <= 1'b0;
            end
        end
    end

    always @* begin
        core_reg_rdata_o = 16'h0000;
        if (core_reg_addr_i == `HMDP_ADDR_OVL_OFFSET) begin
            core_reg_rdata_o = {1'b0, mem_program, host_address_latch_reg};
        end else if (core_reg_addr_i == `HMDP_CONFIG_OFFSET) begin
            core_reg_rdata_o = {1'b0, short_read_mode, 14'h0000};
        end
    end
endmodule

// File: tb/hmdp_port_assertions.sv
// assertion checker for the host memory port
`timescale 1ns/1ps
module hmdp_port_assertions (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        host_port_select_n_i,
    input wire [15:0] host_addr_data_bus_o,
    input wire [15:0] host_addr_data_bus_oe_o,
    input wire        host_ack_n_o,
    input wire        boot_hold_o,
    input wire [13:0] core_reg_addr_i,
    input wire [15:0] core_reg_rdata_o,
    input wire        mem_req_o,
    input wire        mem_we_o,
    input wire        mem_program_o,
    input wire [13:0] mem_addr_o,
    input wire        mem_ready_i,
    input wire [23:0] mem_rdata_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire        rd_acc = mem_req_o && !mem_we_o && !mem_program_o && mem_ready_i;
    wire        wr_req = mem_req_o && mem_we_o;
    wire [15:0] rd_lo  = mem_rdata_i[15:0];
    a_ctrl_write_drop: assert property (wr_req && !mem_program_o |-> mem_addr_o < 14'h3fe0)
        else $error("write issued into control region");
    a_boot_release: assert property ($fell(boot_hold_o) && $past(rst_n_i, 2)
        |-> $past(wr_req && mem_program_o && mem_addr_o == 14'h0))
        else $error("boot hold released without program write to zero");
    a_ack_busy_min: assert property ($rose(host_ack_n_o) |-> host_ack_n_o [*3])
        else $error("acknowledge returned too early");
    a_ack_busy_bound: assert property ($rose(host_ack_n_o) |-> ##[1:100] !host_ack_n_o)
        else $error("acknowledge stuck busy");
    a_req_held_stall: assert property (mem_req_o && !mem_ready_i
        |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
        else $error("memory request dropped while stalled");
    a_read_data_return: assert property (rd_acc ##1 1'b1 |=> host_addr_data_bus_o == $past(rd_lo))
        else $error("read data not returned to host");
    a_oe_released: assert property (host_port_select_n_i [*4] |-> host_addr_data_bus_oe_o == 16'h0)
        else $error("bus driven while deselected");
    a_oe_whole_bus: assert property (host_addr_data_bus_oe_o == 16'h0 || host_addr_data_bus_oe_o == 16'hffff)
        else $error("partial bus drive");
    a_cfg_unused_bits: assert property (core_reg_addr_i == 14'h3fe7
        |-> core_reg_rdata_o[15] == 1'b0 && core_reg_rdata_o[13:0] == 14'h0)
        else $error("unimplemented config bits read nonzero");
    c_read: cover property (rd_acc);
    c_boot: cover property ($fell(boot_hold_o));
    c_stall: cover property (mem_req_o && !mem_ready_i [*8]);
endmodule
bind hmdp_port hmdp_port_assertions i_chk (.*);

// File: tb/hmdp_host_model.sv
// host-side model driving the multiplexed port
`timescale 1ns/1ps
module hmdp_host_model (
    input  wire        clk_i,
    input  wire        ack_n_i,
    input  wire [15:0] bus_i,
    output reg         sel_n_o,
    output reg         als_o,
    output reg         rd_n_o,
    output reg         wr_n_o,
    output reg  [15:0] bus_o
);
    integer errs;
    integer n;
    reg     keep_sel;
    initial begin
        errs = 0;
        keep_sel = 1'b0;
        sel_n_o = 1'b1;
        als_o = 1'b0;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        bus_o = 16'h0;
    end
    task wait_ready;
        begin
            n = 0;
            while (ack_n_i !== 1'b0 && n < 200) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n >= 200) errs = errs + 1;
        end
    endtask
    task latch(input [15:0] v);
        begin
            wait_ready;
            @(posedge clk_i);
            bus_o <= v[15] ? (v & 16'h80ff) : v;
            als_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            als_o <= 1'b0;
            repeat (3) @(posedge clk_i);
            bus_o <= ~bus_o;
            repeat (2) @(posedge clk_i);
        end
    endtask
    task xfer(input wr, input [15:0] v, output [15:0] q);
        begin
            wait_ready;
            @(posedge clk_i);
            sel_n_o <= 1'b0;
            rd_n_o <= wr;
            wr_n_o <= !wr;
            if (wr) bus_o <= v;
            n = 0;
            @(posedge clk_i);
            while (ack_n_i !== 1'b1 && n < 50) begin
                @(posedge clk_i);
                n = n + 1;
            end
            while (ack_n_i !== 1'b0 && n < 300) begin
                @(posedge clk_i);
                n = n + 1;
            end
            if (n >= 300) errs = errs + 1;
            q = bus_i;
            sel_n_o <= !keep_sel;
            rd_n_o <= 1'b1;
            wr_n_o <= 1'b1;
            bus_o <= ~bus_o;
            repeat (3) @(posedge clk_i);
        end
    endtask
    task drop_sel;
        begin
            @(posedge clk_i);
            sel_n_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule

// File: tb/hmdp_port_tb.sv
// testbench for the host memory port
`timescale 1ns/1ps
module hmdp_port_tb;
    reg         clk_i, rst_n_i, core_wr, mem_rdy;
    reg  [2:0]  boot_mode;
    reg  [13:0] core_addr;
    reg  [15:0] core_wdata, q;
    reg  [23:0] mem_rdata;
    reg  [23:0] mem [0:32767];
    wire        sel_n, als, rd_n, wr_n, ack_n, boot_hold, mem_req, mem_we, mem_prog;
    wire [15:0] bus_h, bus_d, oe, core_rdata;
    wire [13:0] mem_addr;
    wire [23:0] mem_wdata;
    wire [7:0]  ovl;
    wire [15:0] bus_w = (oe & bus_d) | (~oe & bus_h);
    integer     failures, tests_run, cyc, i;
    hmdp_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_port_select_n_i(sel_n),
        .address_latch_strobe_i(als), .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n),
        .host_addr_data_bus_i(bus_w), .host_addr_data_bus_o(bus_d), .host_addr_data_bus_oe_o(oe),
        .host_ack_n_o(ack_n), .boot_mode_i(boot_mode), .boot_hold_o(boot_hold), .core_reg_wr_i(core_wr),
        .core_reg_addr_i(core_addr), .core_reg_wdata_i(core_wdata), .core_reg_rdata_o(core_rdata),
        .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_program_o(mem_prog), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .overlay_select_o(ovl), .mem_ready_i(mem_rdy), .mem_rdata_i(mem_rdata));
    hmdp_host_model i_host (.clk_i(clk_i), .ack_n_i(ack_n), .bus_i(bus_w), .sel_n_o(sel_n),
        .als_o(als), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus_h));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (mem_req && mem_rdy && mem_we)
            mem[{mem_prog, mem_addr}] <= mem_wdata;
        mem_rdata <= (mem_req && mem_rdy && !mem_we) ? mem[{mem_prog, mem_addr}] : ~mem_rdata;
    end
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    task chk(input [23:0] g, input [23:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task finish_test;
        begin
            failures = failures + i_host.errs;
            if (failures == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task do_reset(input [2:0] mode);
        begin
            @(posedge clk_i);
            rst_n_i <= 1'b0;
            boot_mode <= mode;
            repeat (10) @(posedge clk_i);
            rst_n_i <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask
    task core_write(input [13:0] a, input [15:0] d);
        begin
            @(posedge clk_i);
            core_wr <= 1'b1;
            core_addr <= a;
            core_wdata <= d;
            @(posedge clk_i);
            core_wr <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task core_read(input [13:0] a);
        begin
            @(posedge clk_i);
            core_addr <= a;
            @(posedge clk_i);
            q = core_rdata;
        end
    endtask
    task t_boot;
        begin
            do_reset(3'h4);
            chk(boot_hold, 1'b0);
            do_reset(3'h5);
            chk(boot_hold, 1'b1);
        end
    endtask
    task t_regs;
        begin
            core_write(14'h3fe7, 16'h4000);
            core_read(14'h3fe7);
            chk(q, 16'h4000);
            core_write(14'h3fe0, 16'h4123);
            core_read(14'h3fe0);
            chk(q, 16'h4123);
            core_write(14'h3fe0, 16'h8003);
            chk(ovl, 8'h03);
            i_host.latch(16'h805a);
            chk(ovl, 8'h5a);
        end
    endtask
    task t_dm_block;
        begin
            i_host.latch(16'h0100);
            for (i = 0; i < 3; i = i + 1)
                i_host.xfer(1'b1, 16'ha5c0 + i[15:0], q);
            core_read(14'h3fe0);
            chk(q, 16'h0103);
            i_host.latch(16'h0100);
            for (i = 0; i < 3; i = i + 1) begin
                i_host.xfer(1'b0, 16'h0, q);
                chk(q, 16'ha5c0 + i[15:0]);
                chk(mem[15'h0100 + i[14:0]][15:0], 16'ha5c0 + i[15:0]);
            end
        end
    endtask
    task t_short_read(input [15:0] cfg, input [15:0] exp_oe);
        begin
            core_write(14'h3fe7, cfg);
            i_host.latch(16'h0100);
            i_host.keep_sel = 1'b1;
            i_host.xfer(1'b0, 16'h0, q);
            chk(q, 16'ha5c0);
            chk(oe, exp_oe);
            i_host.keep_sel = 1'b0;
            i_host.drop_sel;
            chk(oe, 16'h0000);
        end
    endtask
    task t_ctrl_drop;
        begin
            i_host.latch(16'h3fe0);
            i_host.xfer(1'b1, 16'hbeef, q);
            repeat (8) @(posedge clk_i);
            chk(mem[15'h3fe0], 24'h000111);
            core_read(14'h3fe0);
            chk(q, 16'h3fe1);
        end
    endtask
    task t_pm_boot;
        begin
            chk(boot_hold, 1'b1);
            i_host.latch(16'h4000);
            i_host.xfer(1'b1, 16'h1234, q);
            i_host.xfer(1'b1, 16'h0056, q);
            repeat (8) @(posedge clk_i);
            chk(mem[15'h4000], 24'h123456);
            chk(boot_hold, 1'b0);
            i_host.latch(16'h4000);
            i_host.xfer(1'b0, 16'h0, q);
            chk(q, 16'h1234);
            i_host.xfer(1'b0, 16'h0, q);
            chk(q, 16'h0056);
        end
    endtask
    task t_fifo_full;
        begin
            @(posedge clk_i);
            mem_rdy <= 1'b0;
            i_host.latch(16'h0200);
            for (i = 0; i < 16; i = i + 1)
                i_host.xfer(1'b1, 16'h3000 + i[15:0], q);
            fork
                i_host.xfer(1'b1, 16'h3010, q);
                begin
                    repeat (40) @(posedge clk_i);
                    chk(ack_n, 1'b1);
                    mem_rdy <= 1'b1;
                end
            join
            repeat (30) @(posedge clk_i);
            for (i = 0; i < 17; i = i + 1)
                chk(mem[15'h0200 + i[14:0]][15:0], 16'h3000 + i[15:0]);
        end
    endtask
    initial begin
        rst_n_i = 1'b0;
        boot_mode = 3'h0;
        core_wr = 1'b0;
        core_addr = 14'h0;
        core_wdata = 16'h0;
        mem_rdy = 1'b1;
        mem_rdata = 24'h0;
        mem[15'h3fe0] = 24'h000111;
        failures = 0;
        tests_run = 0;
        cyc = 0;
        t_boot;
        t_regs;
        t_dm_block;
        t_short_read(16'h4000, 16'hffff);
        t_short_read(16'h0000, 16'h0000);
        t_ctrl_drop;
        t_pm_boot;
        t_fifo_full;
        finish_test;
    end
endmodule
